// >>> src/adf_ctrl.sv
// Strobed register access was left to the implementer.
`include "adf_regs.svh"

// Contract
// - Threshold field bits 3:0, reset 0x7, 0x3 for diversity.
// - Bit 7 of diversity register reads antenna of last received frame.
// - Status bit holds until a new header locks, then updates (with diversity off it follows static codes 1 and 2 instead).
// - Diversity enable makes device pick antenna during header search.
// - Chosen antenna held until new search, leaving receive, or static write.
// - Switch enable drives complementary pair from algorithm or static field.
// - Switch enable clear holds both switch pins low (pin b still carries the time-stamp when time-stamp enable is set).
// - Time-stamp enable hands second switch pin to time-stamp output.
// - Static field: 0/3 none, 1 antenna zero, 2 antenna one.
// - Static field drives the pins only with diversity off and switch enabled.
// - Static field reaches pins only in PLL-locked and listen states.
// - Front-end pair low/high when idle, swapped while transmitting.
// - Front-end enable clear holds both front-end pins low.
// - Rising edge on sleep/transmit pin is a transmit request.
// - Front-end pair shows transmit 6us after the request.
// - Front-end pair returns to receive 3us after amplifier disable.
// - Keep antenna with valid frame, otherwise alternate antennas.
// - Retry mode: each failed attempt moves to the other antenna.
// - Acknowledgment sent on antenna that received the frame.
module adf_ctrl (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       pll_on_state_i,
	input  wire logic       rx_on_state_i,
	input  wire logic       rx_state_i,
	input  wire logic       shr_search_start_i,
	input  wire logic       shr_detect_i,
	input  wire logic       auto_retry_transmit_mode_i,
	input  wire logic       retry_attempt_i,
	input  wire logic       auto_ack_receive_mode_i,
	input  wire logic       ack_tx_start_i,
	input  wire logic       pa_disable_i,
	input  wire logic       timestamp_i,
	input  wire logic       sleep_transmit_pin_i,
	output logic            antenna_switch_pin_a_o,
	output logic            antenna_switch_pin_b_o,
	output logic            frontend_pin_a_o,
	output logic            frontend_pin_b_o
);
	localparam adf_pkg::adf_cnt_t ON_CYC  = 8'(`ADF_TX_ON_CYC);
	localparam adf_pkg::adf_cnt_t OFF_CYC = 8'(`ADF_TX_OFF_CYC);
	localparam adf_pkg::adf_cnt_t DWELL   = 8'(`ADF_DWELL_CYC);

	// Complementary pair from an antenna choice
	function automatic logic [1:0] adf_pair(input logic ant);
		adf_pair = ant ? 2'h2 : 2'h1;
	endfunction

	logic [3:0] thres_q;                  // Correlator threshold
	logic [1:0] rxrsv_q;                  // Writable reserved bits 5:4
	logic       sel_q;                    // Selected antenna status
	logic       diven_q;
	logic       swen_q;
	logic [1:0] ctrl_q;
	logic       feen_q;
	logic       tsen_q;
	logic       algo_ant_q;               // Antenna the algorithm drives
	logic       locked_q;
	logic [7:0] dwell_q;
	logic [1:0] static_q;                 // Static code applied at pins
	logic       slp_s1_q;
	logic       slp_s2_q;
	logic       slp_s3_q;
	adf_pkg::adf_fe_e  fe_q;
	adf_pkg::adf_cnt_t fe_cnt_q;
	logic [7:0] rdata_d;

	// Register decode
	wire wr_rx  = reg_wr_i && (reg_addr_i == `ADF_RXCTL_OFS);
	wire wr_div = reg_wr_i && (reg_addr_i == `ADF_ANTDIV_OFS);
	wire wr_fe  = reg_wr_i && (reg_addr_i == `ADF_FECTL_OFS);
	wire [7:0] rx_val  = {2'h0, rxrsv_q, thres_q};
	wire [7:0] div_val = {sel_q, 3'h0, diven_q, swen_q, ctrl_q};
	wire [7:0] fe_val  = {feen_q, tsen_q, 6'h00};

	// Read mux, unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ADF_RXCTL_OFS:  rdata_d = rx_val;
				`ADF_ANTDIV_OFS: rdata_d = div_val;
				`ADF_FECTL_OFS:  rdata_d = fe_val;
				default:         rdata_d = 8'h00;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thres_q     <= `ADF_THRES_RST;
			rxrsv_q     <= 2'h3;
			diven_q     <= 1'b0;
			swen_q      <= 1'b0;
			ctrl_q      <= 2'h0;
			feen_q      <= 1'b0;
			tsen_q      <= 1'b0;
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= rdata_d;
			if (wr_rx) begin
				thres_q <= reg_wdata_i[3:0];
				rxrsv_q <= reg_wdata_i[5:4];
			end
			if (wr_div) begin
				diven_q <= reg_wdata_i[`ADF_DIVEN_BIT];
				swen_q  <= reg_wdata_i[`ADF_SWEN_BIT];
				ctrl_q  <= reg_wdata_i[1:0];
			end
			if (wr_fe) begin
				feen_q <= reg_wdata_i[`ADF_FEEN_BIT];
				tsen_q <= reg_wdata_i[`ADF_TSEN_BIT];
			end
		end
	end

	// Antenna search: alternate until a header locks
	wire search_on = diven_q && rx_state_i && !locked_q;
	wire dwell_end = (dwell_q == DWELL - 8'h01);
	// Events that unlock the search or move the algorithm antenna
	wire search_clr = !rx_state_i || shr_search_start_i || wr_div;
	wire retry_hit  = auto_retry_transmit_mode_i && retry_attempt_i;
	wire ack_hit    = auto_ack_receive_mode_i && ack_tx_start_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			algo_ant_q <= 1'b0;
			locked_q   <= 1'b0;
			dwell_q    <= 8'h00;
			sel_q      <= 1'b0;
		end else begin
			if (search_clr) begin
				locked_q <= 1'b0;
				dwell_q  <= 8'h00;
			end else if (diven_q && shr_detect_i && !locked_q) begin
				locked_q <= 1'b1;
				sel_q    <= algo_ant_q;
			end else if (search_on) begin
				dwell_q <= dwell_end ? 8'h00 : dwell_q + 8'h01;
				if (dwell_end)
					algo_ant_q <= !algo_ant_q;
			end
			if (retry_hit)
				algo_ant_q <= !algo_ant_q;
			if (ack_hit)
				algo_ant_q <= sel_q;
			if (!diven_q && static_q == `ADF_ANT0_CODE)
				sel_q <= 1'b0;
			else if (!diven_q && static_q == `ADF_ANT1_CODE)
				sel_q <= 1'b1;
		end
	end

	// Static field latches to the pins only in PLL-locked or listen states
	always_ff @(posedge clk_i) begin
		if (rst_i)
			static_q <= 2'h0;
		else if (pll_on_state_i || rx_on_state_i)
			static_q <= ctrl_q;
	end

	// Switch pin decode
	wire static_valid = (static_q == `ADF_ANT0_CODE) || (static_q == `ADF_ANT1_CODE);
	wire [1:0] sw_pair =
		!swen_q      ? 2'h0 :
		diven_q      ? adf_pair(algo_ant_q) :
		static_valid ? adf_pair(static_q == `ADF_ANT1_CODE) : 2'h0;
	wire sw_b = tsen_q ? timestamp_i : sw_pair[0];

	// Sleep/transmit pin synchroniser and edge detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slp_s1_q <= 1'b0;
			slp_s2_q <= 1'b0;
			slp_s3_q <= 1'b0;
		end else begin
			slp_s1_q <= sleep_transmit_pin_i;
			slp_s2_q <= slp_s1_q;
			slp_s3_q <= slp_s2_q;
		end
	end
	wire tx_req = slp_s2_q && !slp_s3_q;

	// Front-end sequencer with fixed delays
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fe_q     <= adf_pkg::ADF_FE_IDLE;
			fe_cnt_q <= 8'h00;
		end else begin
			unique case (fe_q)
				adf_pkg::ADF_FE_IDLE: if (tx_req) begin
					fe_q     <= adf_pkg::ADF_FE_ON_WAIT;
					fe_cnt_q <= ON_CYC - 8'h01;
				end
				adf_pkg::ADF_FE_ON_WAIT:
					if (fe_cnt_q == 8'h00)
						fe_q <= adf_pkg::ADF_FE_TX;
					else
						fe_cnt_q <= fe_cnt_q - 8'h01;
				adf_pkg::ADF_FE_TX: if (pa_disable_i) begin
					fe_q     <= adf_pkg::ADF_FE_OFF_WAIT;
					fe_cnt_q <= OFF_CYC - 8'h01;
				end
				adf_pkg::ADF_FE_OFF_WAIT:
					if (fe_cnt_q == 8'h00)
						fe_q <= adf_pkg::ADF_FE_IDLE;
					else
						fe_cnt_q <= fe_cnt_q - 8'h01;
			endcase
		end
	end
	wire fe_tx = (fe_q == adf_pkg::ADF_FE_TX) || (fe_q == adf_pkg::ADF_FE_OFF_WAIT);
	wire [1:0] fe_pair = !feen_q ? 2'h0 : (fe_tx ? 2'h2 : 2'h1);

	// Pin registers: both pins of a pair change on the same edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			antenna_switch_pin_a_o <= 1'b0;
			antenna_switch_pin_b_o <= 1'b0;
			frontend_pin_a_o       <= 1'b0;
			frontend_pin_b_o       <= 1'b0;
		end else begin
			antenna_switch_pin_a_o <= sw_pair[1];
			antenna_switch_pin_b_o <= sw_b;
			frontend_pin_a_o       <= fe_pair[1];
			frontend_pin_b_o       <= fe_pair[0];
		end
	end

	// Assertions
	sequence tx_req_s;
		tx_req && fe_q == adf_pkg::ADF_FE_IDLE;
	endsequence
	fe_on_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_req_s |-> ##120 (fe_q != adf_pkg::ADF_FE_TX) ##1 (fe_q == adf_pkg::ADF_FE_TX))
		else $error("front-end transmit delay wrong");
	sequence pa_off_s;
		fe_q == adf_pkg::ADF_FE_TX && pa_disable_i;
	endsequence
	fe_off_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pa_off_s |-> ##60 (fe_q != adf_pkg::ADF_FE_IDLE) ##1 (fe_q == adf_pkg::ADF_FE_IDLE))
		else $error("front-end receive return delay wrong");
	fe_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(frontend_pin_a_o && frontend_pin_b_o))
		else $error("front-end pins both high");
	fe_off_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!feen_q |=> !frontend_pin_a_o && !frontend_pin_b_o)
		else $error("front-end pins not low while disabled");
	sw_off_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!swen_q && !tsen_q) |=> !antenna_switch_pin_a_o && !antenna_switch_pin_b_o)
		else $error("switch pins not low while disabled");
	sw_a_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!swen_q |=> !antenna_switch_pin_a_o)
		else $error("switch pin a not low while disabled");
	sw_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(swen_q && diven_q && !tsen_q) |=> (antenna_switch_pin_a_o != antenna_switch_pin_b_o))
		else $error("switch pair not complementary");
	sel_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(diven_q && !shr_detect_i) |=> $stable(sel_q))
		else $error("selected antenna changed without header");
	thres_rst_a: assert property (@(posedge clk_i)
		rst_i |=> thres_q == `ADF_THRES_RST)
		else $error("threshold reset value wrong");
	static_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(swen_q && !diven_q && !tsen_q && static_q == `ADF_ANT0_CODE)
		|=> !antenna_switch_pin_a_o && antenna_switch_pin_b_o)
		else $error("static antenna zero not driven");
	tx_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(fe_q == adf_pkg::ADF_FE_IDLE && $rose(slp_s2_q)) |=> fe_q == adf_pkg::ADF_FE_ON_WAIT)
		else $error("transmit request not taken");

	// Switch pin pair against configuration
	static_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(swen_q && !diven_q && !tsen_q && static_q == `ADF_ANT1_CODE)
		|=> antenna_switch_pin_a_o && !antenna_switch_pin_b_o)
		else $error("static antenna one not driven");
	static_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(swen_q && !diven_q && !tsen_q && !static_valid)
		|=> !antenna_switch_pin_a_o && !antenna_switch_pin_b_o)
		else $error("switch pins driven without static selection");
	ts_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tsen_q |=> antenna_switch_pin_b_o == $past(timestamp_i))
		else $error("time-stamp not on switch pin b");
	sw_algo_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(swen_q && diven_q) |=> antenna_switch_pin_a_o == $past(algo_ant_q))
		else $error("switch pins not following algorithm antenna");
	sw_no_clash_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!tsen_q |=> !(antenna_switch_pin_a_o && antenna_switch_pin_b_o))
		else $error("switch pins both high");
	static_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!pll_on_state_i && !rx_on_state_i) |=> $stable(static_q))
		else $error("static code applied outside locked or listen state");
	static_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(pll_on_state_i || rx_on_state_i) |=> static_q == $past(ctrl_q))
		else $error("static code not applied in locked or listen state");

	// Front-end pair levels and request handling
	fe_rx_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(feen_q && !fe_tx) |=> !frontend_pin_a_o && frontend_pin_b_o)
		else $error("front-end receive indication wrong");
	fe_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(feen_q && fe_tx) |=> frontend_pin_a_o && !frontend_pin_b_o)
		else $error("front-end transmit indication wrong");
	fe_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(fe_q == adf_pkg::ADF_FE_ON_WAIT && fe_cnt_q != 8'h00) |=> fe_q == adf_pkg::ADF_FE_ON_WAIT)
		else $error("front-end left transmit wait early");

	// Search, lock and antenna moves
	sequence lock_s;
		!search_clr && diven_q && shr_detect_i && !locked_q;
	endsequence
	lock_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		lock_s |=> locked_q && sel_q == $past(algo_ant_q))
		else $error("header lock did not update status");
	search_unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		search_clr |=> !locked_q)
		else $error("search not unlocked");
	lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(locked_q && !search_clr && !retry_hit && !ack_hit)
		|=> $stable(algo_ant_q))
		else $error("locked antenna changed");
	ant_alternate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(search_on && dwell_end && !search_clr && !shr_detect_i && !retry_hit && !ack_hit)
		|=> algo_ant_q != $past(algo_ant_q))
		else $error("search did not alternate antennas");
	retry_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(retry_hit && !ack_hit) |=> algo_ant_q != $past(algo_ant_q))
		else $error("retry did not move to other antenna");
	ack_ant_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_hit |=> algo_ant_q == $past(sel_q))
		else $error("acknowledgment not on receive antenna");

	// Register side
	rd_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `ADF_ANTDIV_OFS)
		|=> reg_rdata_o[7] == $past(sel_q) && reg_rdata_o[6:4] == 3'h0)
		else $error("selected antenna readback wrong");
	thres_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_rx |=> {4'h0, thres_q} == ($past(reg_wdata_i) & 8'h0F))
		else $error("threshold write not stored");
endmodule // adf_ctrl

// >>> src/adf_regs.svh
`ifndef ADF_REGS_SVH
`define ADF_REGS_SVH
// Register offsets on the plain register port
`define ADF_RXCTL_OFS     8'h0A
`define ADF_ANTDIV_OFS    8'h0D
`define ADF_FECTL_OFS     8'h04
// Reset values
`define ADF_RXCTL_RST     8'h37
`define ADF_ANTDIV_RST    8'h00
`define ADF_FECTL_RST     8'h00
`define ADF_THRES_RST     4'h7
`define ADF_THRES_DIV     4'h3
// Field positions
`define ADF_SEL_BIT       7
`define ADF_DIVEN_BIT     3
`define ADF_SWEN_BIT      2
`define ADF_FEEN_BIT      7
`define ADF_TSEN_BIT      6
// Static antenna codes
`define ADF_ANT0_CODE     2'h1
`define ADF_ANT1_CODE     2'h2
// Timing: clock in MHz, delays in microseconds
`define ADF_CLK_MHZ       20
`define ADF_TX_ON_US      6
`define ADF_TX_OFF_US     3
`define ADF_TX_ON_CYC     (`ADF_TX_ON_US * `ADF_CLK_MHZ)
`define ADF_TX_OFF_CYC    (`ADF_TX_OFF_US * `ADF_CLK_MHZ)
// Antenna dwell time during header search, in cycles
`define ADF_DWELL_CYC     16
`endif

// >>> src/adf_pkg.sv
package adf_pkg;
	typedef enum logic [1:0] {
		ADF_FE_IDLE,
		ADF_FE_ON_WAIT,
		ADF_FE_TX,
		ADF_FE_OFF_WAIT
	} adf_fe_e;
	typedef logic [7:0] adf_cnt_t;
endpackage

// >>> test/adf_fe_model.sv
// Far side: antenna switch and front-end amplifier path
module adf_fe_model (
	input  wire logic sw_a_i,
	input  wire logic sw_b_i,
	input  wire logic fe_a_i,
	input  wire logic fe_b_i,
	output logic      ant1_o,
	output logic      tx_o,
	output logic      clash_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Switch routes antenna one when pin a is high and pin b low
	assign ant1_o = sw_a_i & ~sw_b_i;
	// Amplifier path in transmit when pin a is high and pin b low
	assign tx_o = fe_a_i & ~fe_b_i;
	// Both inputs of one pair high would short the switch drive
	assign clash_o = (sw_a_i & sw_b_i) | (fe_a_i & fe_b_i);
endmodule // adf_fe_model

// >>> test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [7:0] addr  = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] v;
	logic       wr = 1'b0, rd = 1'b0, pll = 1'b0, rxst = 1'b0, srch = 1'b0;
	logic       det = 1'b0, rmode = 1'b0, ratt = 1'b0, pad = 1'b0, ts = 1'b0;
	logic       slp = 1'b0, sa, sb, fa, fb, ant1, tx, clash, s;
	logic       rxon = 1'b0, amode = 1'b0, ack = 1'b0;
	int         n_errors = 0;
	int         checks_done = 0;
	int         n;
	// Clock of 50 ns period
	initial forever #25 clk_i = ~clk_i;
	adf_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pll_on_state_i(pll),
		.rx_on_state_i(rxon), .rx_state_i(rxst), .shr_search_start_i(srch),
		.shr_detect_i(det), .auto_retry_transmit_mode_i(rmode), .retry_attempt_i(ratt),
		.auto_ack_receive_mode_i(amode), .ack_tx_start_i(ack), .pa_disable_i(pad),
		.timestamp_i(ts), .sleep_transmit_pin_i(slp), .antenna_switch_pin_a_o(sa),
		.antenna_switch_pin_b_o(sb), .frontend_pin_a_o(fa), .frontend_pin_b_o(fb));
	adf_fe_model far (.sw_a_i(sa), .sw_b_i(sb), .fe_a_i(fa), .fe_b_i(fb), .ant1_o(ant1),
		.tx_o(tx), .clash_o(clash));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(negedge clk_i);
		d = rdata;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	// Cycles until front-end pin a reaches a level, bounded
	task automatic wait_fe(input logic lvl, output int k);
		k = 0;
		while (fa !== lvl && k < 400) begin
			@(negedge clk_i);
			k++;
		end
		if (k >= 400) begin
			n_errors++;
			print_verdict();
		end
	endtask
	task automatic toggles(input int c, output int k);
		logic p;
		k = 0;
		p = sa;
		repeat (c) begin
			@(negedge clk_i);
			if (sa !== p) k++;
			p = sa;
		end
	endtask
	task automatic test_regs();
		rd_reg(8'h0A, v); chk(v, 8'h37);
		rd_reg(8'h0D, v); chk(v, 8'h00);
		rd_reg(8'h01, v); chk(v, 8'h00);
		wr_reg(8'h0A, 8'hF3);
		rd_reg(8'h0A, v); chk(v, 8'h33);
		$display("test regs done");
	endtask
	task automatic test_static();
		wr_reg(8'h0D, 8'h05);
		pll <= 1'b1;
		settle(3); chk({sa, sb, ant1}, 3'b010);
		rd_reg(8'h0D, v); chk(v, 8'h05);
		wr_reg(8'h04, 8'h40);
		settle(2); chk({sa, sb}, 2'b00);
		@(posedge clk_i);
		ts <= 1'b1;
		settle(2); chk({sa, sb}, 2'b01);
		@(posedge clk_i);
		ts <= 1'b0;
		wr_reg(8'h04, 8'h00);
		pll <= 1'b0;
		wr_reg(8'h0D, 8'h06);
		settle(2); chk({sa, sb, ant1}, 3'b010);
		@(posedge clk_i);
		rxon <= 1'b1;
		settle(3); chk({sa, sb, ant1}, 3'b101);
		rd_reg(8'h0D, v); chk(v, 8'h86);
		wr_reg(8'h0D, 8'h02);
		settle(2); chk({sa, sb}, 2'b00);
		$display("test static done");
	endtask
	task automatic test_fe();
		settle(1); chk({fa, fb}, 2'b00);
		wr_reg(8'h04, 8'h80);
		settle(2); chk({fa, fb, tx}, 3'b010);
		@(posedge clk_i);
		slp <= 1'b1;
		wait_fe(1'b1, n); chk(8'(n >= 120 && n <= 126), 8'h01);
		chk({fa, fb, tx}, 3'b101);
		@(posedge clk_i);
		pad <= 1'b1;
		@(posedge clk_i);
		pad <= 1'b0;
		slp <= 1'b0;
		wait_fe(1'b0, n); chk(8'(n >= 58 && n <= 63), 8'h01);
		chk({fa, fb}, 2'b01);
		wr_reg(8'h04, 8'h00);
		settle(2); chk({fa, fb}, 2'b00);
		$display("test front end done");
	endtask
	task automatic test_div();
		wr_reg(8'h0A, 8'h33);
		wr_reg(8'h0D, 8'h0C);
		rxst <= 1'b1;
		toggles(40, n); chk(8'(n >= 2), 8'h01);
		@(posedge clk_i);
		det <= 1'b1;
		@(posedge clk_i);
		det <= 1'b0;
		settle(1);
		s = sa;
		toggles(40, n); chk(8'(n), 8'h00);
		rd_reg(8'h0D, v); chk(v, {s, 7'h0C});
		@(posedge clk_i);
		rmode <= 1'b1;
		ratt <= 1'b1;
		@(posedge clk_i);
		rmode <= 1'b0;
		ratt <= 1'b0;
		settle(2); chk(sa, !s);
		@(posedge clk_i);
		amode <= 1'b1;
		ack <= 1'b1;
		@(posedge clk_i);
		amode <= 1'b0;
		ack <= 1'b0;
		settle(2); chk(sa, s);
		@(posedge clk_i);
		srch <= 1'b1;
		@(posedge clk_i);
		srch <= 1'b0;
		toggles(40, n); chk(8'(n >= 2), 8'h01);
		rd_reg(8'h0D, v); chk(v, {s, 7'h0C});
		@(posedge clk_i);
		rxst <= 1'b0;
		wr_reg(8'h0A, 8'h37);
		rd_reg(8'h0A, v); chk(v, 8'h37);
		wr_reg(8'h0D, 8'h00);
		settle(2); chk({sa, sb}, 2'b00);
		$display("test diversity done");
	endtask
	// Neither pair may ever show both pins high
	always @(negedge clk_i) begin
		if (clash === 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, 1'b1, 1'b0);
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		test_regs();
		test_static();
		test_fe();
		test_div();
		print_verdict();
	end
endmodule // tb
